// File: core/gph_pin_ctrl.sv
/*
 * Pin control for an eight-pin port (with three external interrupt
 * inputs) and a four-pin port, behind an AXI4-Lite register slave.
 * Assumes pad inputs synchronous to clock and a pad ring that resolves
 * out/oe/pull into the pin level.
 */
// Function
// - Eight-pin function-select bits 2..0 keep external interrupt 2..0 live in deep standby.
// - Function-select bits 31..3 read zero and ignore writes.
// - Eight-pin drive-type bit per pin: 0 push-pull, 1 open-drain.
// - Eight-pin pull-up enable bit per pin; bits 31..8 read zero.
// - Eight-pin pull-down enable bit per pin; upper bits read zero.
// - Eight-pin input-enable bit per pin; 0 blocks the pin input.
// - Four-pin port gives four pins usable as input or output.
// - Four-pin port direction is set per pin, not per port.
// - After reset four-pin port has input, output and pulls off.
// - Four-pin data at 0x0000, output enable at 0x0004.
// - Four-pin drive type at 0x0028, pull-up at 0x002C.
// - Four-pin pull-down at 0x0030, input enable at 0x0038.
// - After reset eight-pin port has input, output and pulls off.
// - Outside deep standby, interrupt input live whenever input enabled.
`default_nettype none

module gph_pin_ctrl (
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    input  wire logic [gph_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [gph_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic                         standby_stop,
    input  wire logic                         standby_pin_drive_keep,
    input  wire logic [gph_pkg::H_W-1:0]      pin_h_in,
    input  wire logic [gph_pkg::I_W-1:0]      pin_i_in,
    output gph_pkg::gph_pads_h_t              pads_h,
    output gph_pkg::gph_pads_i_t              pads_i,
    output logic [gph_pkg::INT_W-1:0]         external_interrupt,
    output logic                              irq
);

    // ******************************************************************
    // Storage
    // ******************************************************************
    logic [gph_pkg::H_W-1:0]   data_h_q, oe_h_q, od_h_q, pu_h_q, pd_h_q;
    logic [gph_pkg::H_W-1:0]   ie_h_q;
    logic [gph_pkg::INT_W-1:0] fsel_h_q;
    logic [gph_pkg::I_W-1:0]   data_i_q, oe_i_q, od_i_q, pu_i_q, pd_i_q;
    logic [gph_pkg::I_W-1:0]   ie_i_q;
    logic [gph_pkg::INT_W-1:0] stat_q, mask_q, ext_q, ext_d;
    logic                      irq_q;
    gph_pkg::gph_pads_h_t      pads_h_q, pads_h_d;
    gph_pkg::gph_pads_i_t      pads_i_q, pads_i_d;

    logic                        aw_got_q, w_got_q, awready_q, wready_q;
    logic                        bvalid_q, arready_q, rvalid_q;
    logic [1:0]                  bresp_q, rresp_q;
    logic [31:0]                 wdata_q, rdata_q, rdata_d;
    logic [3:0]                  wstrb_q;
    logic [gph_pkg::ADDR_W-1:0]  awaddr_q, waddr, raddr;
    logic                        wr_fire, rd_fire, rd_ok;
    logic [7:0]                  wbyte;

    assign waddr   = {awaddr_q[gph_pkg::ADDR_W-1:2], 2'h0};
    assign raddr   = {s_axi_araddr[gph_pkg::ADDR_W-1:2], 2'h0};
    assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
    assign rd_fire = s_axi_arvalid && arready_q;
    // Only the low byte lane holds live bits; other lanes are discarded.
    assign wbyte   = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

    function automatic logic is_mapped(input logic [7:0] a);
        unique case (a)
            gph_pkg::OFS_I_DATA, gph_pkg::OFS_I_OE, gph_pkg::OFS_I_OD,
            gph_pkg::OFS_I_PU, gph_pkg::OFS_I_PD, gph_pkg::OFS_I_IE,
            gph_pkg::OFS_H_DATA, gph_pkg::OFS_H_OE, gph_pkg::OFS_H_FSEL,
            gph_pkg::OFS_H_OD, gph_pkg::OFS_H_PU, gph_pkg::OFS_H_PD,
            gph_pkg::OFS_H_IE, gph_pkg::OFS_IRQ_STAT,
            gph_pkg::OFS_IRQ_MASK: is_mapped = 1'b1;
            default:              is_mapped = 1'b0;
        endcase
    endfunction

    // ******************************************************************
    // Write channel
    // ******************************************************************
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= gph_pkg::RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                aw_got_q  <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end else if (!aw_got_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
            if (s_axi_wvalid && wready_q) begin
                w_got_q  <= 1'b1;
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (!w_got_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= is_mapped(waddr) ? gph_pkg::RESP_OKAY
                                             : gph_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ******************************************************************
    // Eight-pin port configuration
    // ******************************************************************
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            data_h_q <= gph_pkg::RST_CFG;
            oe_h_q   <= gph_pkg::RST_CFG;
            od_h_q   <= gph_pkg::RST_CFG;
            pu_h_q   <= gph_pkg::RST_CFG;
            pd_h_q   <= gph_pkg::RST_CFG;
            ie_h_q   <= gph_pkg::RST_CFG;
            fsel_h_q <= '0;
        end else if (wr_fire && wstrb_q[0]) begin
            unique case (waddr)
                gph_pkg::OFS_H_DATA: data_h_q <= wbyte;
                gph_pkg::OFS_H_OE:   oe_h_q   <= wbyte;
                gph_pkg::OFS_H_FSEL: fsel_h_q <= wbyte[2:0];
                gph_pkg::OFS_H_OD:   od_h_q   <= wbyte;
                gph_pkg::OFS_H_PU:   pu_h_q   <= wbyte;
                gph_pkg::OFS_H_PD:   pd_h_q   <= wbyte;
                gph_pkg::OFS_H_IE:   ie_h_q   <= wbyte;
                default: ;
            endcase
        end
    end

    // ******************************************************************
    // Four-pin port configuration
    // ******************************************************************
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            data_i_q <= '0;
            oe_i_q   <= '0;
            od_i_q   <= '0;
            pu_i_q   <= '0;
            pd_i_q   <= '0;
            ie_i_q   <= '0;
        end else if (wr_fire && wstrb_q[0]) begin
            unique case (waddr)
                gph_pkg::OFS_I_DATA: data_i_q <= wbyte[3:0];
                gph_pkg::OFS_I_OE:   oe_i_q   <= wbyte[3:0];
                gph_pkg::OFS_I_OD:   od_i_q   <= wbyte[3:0];
                gph_pkg::OFS_I_PU:   pu_i_q   <= wbyte[3:0];
                gph_pkg::OFS_I_PD:   pd_i_q   <= wbyte[3:0];
                gph_pkg::OFS_I_IE:   ie_i_q   <= wbyte[3:0];
                default: ;
            endcase
        end
    end

    // ******************************************************************
    // Pad drive
    // ******************************************************************
    // Drivers drop in deep standby unless software asked to keep them;
    // pulls stay as programmed so a released line does not float.
    logic drive_ok;
    assign drive_ok = !standby_stop || standby_pin_drive_keep;

    for (genvar b = 0; b < gph_pkg::H_W; b++) begin : g_pad_h
        always_comb begin
            pads_h_d.out[b] = data_h_q[b] && !od_h_q[b];
            pads_h_d.oe[b]  = oe_h_q[b] && drive_ok
                              && (!od_h_q[b] || !data_h_q[b]);
            pads_h_d.pu[b]  = pu_h_q[b];
            pads_h_d.pd[b]  = pd_h_q[b];
        end
    end

    for (genvar b = 0; b < gph_pkg::I_W; b++) begin : g_pad_i
        always_comb begin
            pads_i_d.out[b] = data_i_q[b] && !od_i_q[b];
            pads_i_d.oe[b]  = oe_i_q[b] && drive_ok
                              && (!od_i_q[b] || !data_i_q[b]);
            pads_i_d.pu[b]  = pu_i_q[b];
            pads_i_d.pd[b]  = pd_i_q[b];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pads_h_q <= '0;
            pads_i_q <= '0;
        end else begin
            pads_h_q <= pads_h_d;
            pads_i_q <= pads_i_d;
        end
    end

    // ******************************************************************
    // External interrupt inputs and event flags
    // ******************************************************************
    // In deep standby only pins routed to the interrupt function stay live;
    // otherwise input enable alone is enough, so unused ones must be
    // disabled by software.
    for (genvar k = 0; k < gph_pkg::INT_W; k++) begin : g_ext
        assign ext_d[k] = pin_h_in[k] && ie_h_q[k]
                          && (!standby_stop || fsel_h_q[k]);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ext_q  <= '0;
            stat_q <= '0;
            mask_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            ext_q <= ext_d;
            // A new rising edge wins over a same-cycle write-one clear.
            if (wr_fire && wstrb_q[0] && waddr == gph_pkg::OFS_IRQ_STAT) begin
                stat_q <= (stat_q & ~wbyte[2:0]) | (ext_d & ~ext_q);
            end else begin
                stat_q <= stat_q | (ext_d & ~ext_q);
            end
            if (wr_fire && wstrb_q[0] && waddr == gph_pkg::OFS_IRQ_MASK) begin
                mask_q <= wbyte[2:0];
            end
            // A set mask bit keeps its flag off the interrupt line.
            irq_q <= |(stat_q & ~mask_q);
        end
    end

    // ******************************************************************
    // Read channel
    // ******************************************************************
    always_comb begin
        rdata_d = 32'h0000_0000;
        rd_ok   = is_mapped(raddr);
        unique case (raddr)
            gph_pkg::OFS_I_DATA:
                rdata_d[3:0] = (pin_i_in & ie_i_q) | (data_i_q & ~ie_i_q);
            gph_pkg::OFS_I_OE:     rdata_d[3:0] = oe_i_q;
            gph_pkg::OFS_I_OD:     rdata_d[3:0] = od_i_q;
            gph_pkg::OFS_I_PU:     rdata_d[3:0] = pu_i_q;
            gph_pkg::OFS_I_PD:     rdata_d[3:0] = pd_i_q;
            gph_pkg::OFS_I_IE:     rdata_d[3:0] = ie_i_q;
            gph_pkg::OFS_H_DATA:
                rdata_d[7:0] = (pin_h_in & ie_h_q) | (data_h_q & ~ie_h_q);
            gph_pkg::OFS_H_OE:     rdata_d[7:0] = oe_h_q;
            gph_pkg::OFS_H_FSEL:   rdata_d[2:0] = fsel_h_q;
            gph_pkg::OFS_H_OD:     rdata_d[7:0] = od_h_q;
            gph_pkg::OFS_H_PU:     rdata_d[7:0] = pu_h_q;
            gph_pkg::OFS_H_PD:     rdata_d[7:0] = pd_h_q;
            gph_pkg::OFS_H_IE:     rdata_d[7:0] = ie_h_q;
            gph_pkg::OFS_IRQ_STAT: rdata_d[2:0] = stat_q;
            gph_pkg::OFS_IRQ_MASK: rdata_d[2:0] = mask_q;
            default: ;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= gph_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rdata_d;
            rresp_q   <= rd_ok ? gph_pkg::RESP_OKAY : gph_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready      = awready_q;
    assign s_axi_wready       = wready_q;
    assign s_axi_bvalid       = bvalid_q;
    assign s_axi_bresp        = bresp_q;
    assign s_axi_arready      = arready_q;
    assign s_axi_rvalid       = rvalid_q;
    assign s_axi_rdata        = rdata_q;
    assign s_axi_rresp        = rresp_q;
    assign pads_h             = pads_h_q;
    assign pads_i             = pads_i_q;
    assign external_interrupt = ext_q;
    assign irq                = irq_q;

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    fsel_upper_zero_a: assert property (
        rd_fire && raddr == gph_pkg::OFS_H_FSEL
        |=> rdata_q[31:3] == 29'h0 && rdata_q[2:0] == $past(fsel_h_q))
        else $error("function select read shows upper bits or wrong value");

    ext_route_a: assert property (
        ie_h_q[0] && pin_h_in[0] && !standby_stop
        |=> external_interrupt[0])
        else $error("enabled interrupt input not live outside standby");

    standby_gate_a: assert property (
        standby_stop && !fsel_h_q[1] |=> !external_interrupt[1])
        else $error("unrouted interrupt input live in standby");

    input_block_a: assert property (
        ie_h_q[2:0] == 3'h0 |=> external_interrupt == 3'h0)
        else $error("blocked input reached interrupt path");

    od_high_float_a: assert property (
        (pads_h.oe & $past(od_h_q) & ($past(data_h_q) | pads_h.out))
        == 8'h00)
        else $error("open-drain pin drives a high level");

    cfg_upper_zero_a: assert property (
        rd_fire && (raddr == gph_pkg::OFS_H_PU || raddr == gph_pkg::OFS_H_PD)
        |=> rdata_q[31:8] == 24'h0)
        else $error("pull register upper bits not zero");

    reset_quiet_a: assert property (
        $rose(reset_n) |-> pads_h == '0 && pads_i == '0 && !irq)
        else $error("pads not idle right after reset");

    port_i_oe_a: assert property (
        wr_fire && wstrb_q[0] && waddr == gph_pkg::OFS_I_OE
        |=> oe_i_q == wdata_q[3:0] ##1 pads_i.oe ==
            (oe_i_q & {gph_pkg::I_W{$past(drive_ok)}}
             & ~($past(od_i_q) & $past(data_i_q))))
        else $error("four-pin output enable not decoded at its offset");

    port_i_ie_a: assert property (
        rd_fire && raddr == gph_pkg::OFS_I_IE
        |=> rdata_q[3:0] == $past(ie_i_q) && rresp_q == gph_pkg::RESP_OKAY)
        else $error("four-pin input enable not read at its offset");

    irq_level_a: assert property (
        1'b1 |=> irq == (($past(stat_q) & ~$past(mask_q)) != 3'h0))
        else $error("interrupt output missing for unmasked flag");

    write_resp_a: assert property (
        wr_fire |=> s_axi_bvalid ##0 !s_axi_awready && !s_axi_wready)
        else $error("write response not raised one cycle after both halves");

    wr_seen_c:  cover property (wr_fire ##[1:4] s_axi_bvalid && s_axi_bready);
    rd_seen_c:  cover property (rd_fire ##1 s_axi_rvalid && s_axi_rready);
    irq_rise_c: cover property ($rose(irq));
    wake_c:     cover property (standby_stop && $rose(external_interrupt[0]));

endmodule // gph_pin_ctrl

`default_nettype wire

// File: common/gph_pkg.sv
/*
 * Package for the two-port pin control slice: register byte offsets,
 * port widths, bus answers and the pad bundles carried to the pin ring.
 * Assumes one 32-bit register bus with 8 address bits decoded.
 */
`default_nettype none

package gph_pkg;

    // ******************************************************************
    // Widths
    // ******************************************************************
    localparam int ADDR_W = 8;
    localparam int H_W    = 8;
    localparam int I_W    = 4;
    localparam int INT_W  = 3;

    // ******************************************************************
    // Register byte offsets
    // ******************************************************************
    localparam logic [7:0] OFS_I_DATA   = 8'h00;
    localparam logic [7:0] OFS_I_OE     = 8'h04;
    localparam logic [7:0] OFS_I_OD     = 8'h28;
    localparam logic [7:0] OFS_I_PU     = 8'h2C;
    localparam logic [7:0] OFS_I_PD     = 8'h30;
    localparam logic [7:0] OFS_I_IE     = 8'h38;
    localparam logic [7:0] OFS_H_DATA   = 8'h40;
    localparam logic [7:0] OFS_H_OE     = 8'h44;
    localparam logic [7:0] OFS_H_FSEL   = 8'h48;
    localparam logic [7:0] OFS_H_OD     = 8'h68;
    localparam logic [7:0] OFS_H_PU     = 8'h6C;
    localparam logic [7:0] OFS_H_PD     = 8'h70;
    localparam logic [7:0] OFS_H_IE     = 8'h78;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h80;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h84;

    // ******************************************************************
    // Reset values and bus answers
    // ******************************************************************
    localparam logic [7:0]  RST_CFG     = 8'h00;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ******************************************************************
    // Pad bundles
    // ******************************************************************
    typedef struct packed {
        logic [H_W-1:0] out;
        logic [H_W-1:0] oe;
        logic [H_W-1:0] pu;
        logic [H_W-1:0] pd;
    } gph_pads_h_t;

    typedef struct packed {
        logic [I_W-1:0] out;
        logic [I_W-1:0] oe;
        logic [I_W-1:0] pu;
        logic [I_W-1:0] pd;
    } gph_pads_i_t;

endpackage

`default_nettype wire

// File: tb/gph_pin_board.sv
/*
 * Board model for the pin ring: resolves pad controls, board drivers
 * and pulls into pin levels. Assumes the block's clock.
 */
`default_nettype none

module gph_pin_board (
    input  wire logic                 clock,
    input  wire gph_pkg::gph_pads_h_t pads_h,
    input  wire gph_pkg::gph_pads_i_t pads_i,
    input  wire logic [7:0]           ext_h,
    input  wire logic [7:0]           ext_en_h,
    input  wire logic [3:0]           ext_i,
    input  wire logic [3:0]           ext_en_i,
    output logic [7:0]                pin_h_in,
    output logic [3:0]                pin_i_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ******************************************************************
    // Pin resolution
    // ******************************************************************
    // A floating pin toggles so that a stale level is never trusted.
    logic flt_q = 1'h0;

    always @(posedge clock) begin
        flt_q <= ~flt_q;
    end

    assign pin_h_in = (ext_en_h & ext_h)
        | (~ext_en_h & pads_h.oe & pads_h.out)
        | (~ext_en_h & ~pads_h.oe & (pads_h.pu | (~pads_h.pd & {8{flt_q}})));
    assign pin_i_in = (ext_en_i & ext_i)
        | (~ext_en_i & pads_i.oe & pads_i.out)
        | (~ext_en_i & ~pads_i.oe & (pads_i.pu | (~pads_i.pd & {4{flt_q}})));

endmodule // gph_pin_board

`default_nettype wire

// File: tb/gph_pin_ctrl_tb.sv
/*
 * Self-checking bench for the pin control slice over AXI4-Lite.
 * Assumes the board model and mask bit 1 meaning masked.
 */
`default_nettype none

module gph_pin_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ******************************************************************
    // Signals
    // ******************************************************************
    logic        clock = 1'h0, reset_n = 1'h0, stby = 1'h0, keep = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ext_h = 8'h00;
    logic [7:0]  ext_en_h = 8'h00, pin_h;
    logic [3:0]  ext_i = 4'h0, ext_en_i = 4'h0, pin_i;
    logic [3:0]  wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, d, v;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  ext_int;
    gph_pkg::gph_pads_h_t pads_h;
    gph_pkg::gph_pads_i_t pads_i;
    int          error_cnt = 0, comparisons = 0;
    localparam logic [7:0] REGS [15] = '{8'h04, 8'h28, 8'h2C, 8'h30, 8'h38,
        8'h44, 8'h48, 8'h68, 8'h6C, 8'h70, 8'h78, 8'h00, 8'h40, 8'h80, 8'h84};

    gph_pin_ctrl dut (.clock(clock), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .standby_stop(stby),
        .standby_pin_drive_keep(keep), .pin_h_in(pin_h), .pin_i_in(pin_i),
        .pads_h(pads_h), .pads_i(pads_i), .external_interrupt(ext_int),
        .irq(irq));
    gph_pin_board board (.clock(clock), .pads_h(pads_h), .pads_i(pads_i),
        .ext_h(ext_h), .ext_en_h(ext_en_h), .ext_i(ext_i),
        .ext_en_i(ext_en_i), .pin_h_in(pin_h), .pin_i_in(pin_i));

    // ******************************************************************
    // Tasks
    // ******************************************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge clock);
        awaddr <= a;
        wdata <= x;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge clock);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        r = bresp;
        chk("bvalid", 32'h1, {31'h0, bvalid});
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge clock);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        rready <= 1'h0;
    endtask

    function automatic logic [31:0] cfg_mask(input logic [7:0] a);
        if (a == gph_pkg::OFS_H_FSEL) return 32'h7;
        return (a < 8'h40) ? 32'hF : 32'hFF;
    endfunction

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ******************************************************************
    // Sequence
    // ******************************************************************
    initial begin
        forever #12.5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        test_done();
    end

    initial begin
        void'($urandom(4593));
        repeat (16) @(posedge clock);
        reset_n <= 1'h1;
        chk("pads_h", 32'h0, pads_h);
        chk("pads_i", 32'h0, {16'h0, pads_i});
        for (int i = 0; i < 15; i++) begin
            rd(REGS[i]);
            chk("reset value", 32'h0, d);
        end
        $display("test reset done");
        for (int i = 0; i < 33; i++) begin
            v = $urandom;
            wr(REGS[i % 11], v);
            rd(REGS[i % 11]);
            chk("readback", v & cfg_mask(REGS[i % 11]), d);
            chk("resp", 32'h0, {r, bresp});
        end
        for (int i = 0; i < 2; i++) begin
            wr(i ? 8'hFC : 8'h08, 32'hFFFFFFFF);
            chk("unmapped bresp", 32'h2, {30'h0, r});
            rd(i ? 8'hFC : 8'h08);
            chk("unmapped read", 32'h0, d);
            chk("unmapped rresp", 32'h2, {30'h0, r});
        end
        rd(8'h6C);
        v = d;
        wstrb <= 4'hE;
        wr(8'h6C, ~v);
        wstrb <= 4'hF;
        rd(8'h6C);
        chk("strobe", v, d);
        $display("test registers done");
        ext_i <= 4'($urandom);
        ext_en_i <= 4'hA;
        wr(8'h28, 32'h0);
        wr(8'h2C, 32'h0);
        wr(8'h30, 32'h0);
        wr(8'h00, 32'hA);
        wr(8'h04, 32'h5);
        wr(8'h38, 32'hF);
        rd(8'h00);
        chk("pads_i oe", 32'h5, {28'h0, pads_i.oe});
        chk("pads_i out", 32'hA, {28'h0, pads_i.out});
        chk("port i data", {28'h0, ext_i & 4'hA}, d);
        $display("test four-pin port done");
        wr(8'h40, 32'h5A);
        wr(8'h44, 32'hFF);
        wr(8'h68, 32'hFF);
        wr(8'h6C, 32'h0F);
        wr(8'h70, 32'hF0);
        @(posedge clock);
        chk("open drain oe", 32'hA5, {24'h0, pads_h.oe});
        chk("open drain out", 32'h0, {24'h0, pads_h.out});
        chk("pulls", 32'h0FF0, {16'h0, pads_h.pu, pads_h.pd});
        stby <= 1'h1;
        repeat (3) @(posedge clock);
        chk("standby oe", 32'h0, {24'h0, pads_h.oe});
        keep <= 1'h1;
        repeat (3) @(posedge clock);
        chk("kept oe", 32'hA5, {24'h0, pads_h.oe});
        stby <= 1'h0;
        $display("test eight-pin pads done");
        ext_en_h <= 8'h07;
        wr(8'h44, 32'h0);
        wr(8'h48, 32'h0);
        wr(8'h78, 32'h7);
        wr(8'h80, 32'h7);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) wr(8'h78, 32'h0);
            ext_h <= 8'h07 & (8'h01 << i) | {5'h0, {3{i == 3}}};
            repeat (4) @(posedge clock);
            chk("ext_int", 32'h7 & (32'h1 << i), {29'h0, ext_int});
            chk("irq", {31'h0, i < 3}, {31'h0, irq});
            rd(8'h80);
            chk("status", 32'h7 & (32'h1 << i), d);
            wr(8'h84, 32'h7);
            @(posedge clock);
            chk("masked irq", 32'h0, {31'h0, irq});
            wr(8'h80, 32'h7);
            wr(8'h84, 32'h0);
            rd(8'h80);
            chk("cleared", 32'h0, d);
            ext_h <= 8'h00;
            repeat (4) @(posedge clock);
        end
        stby <= 1'h1;
        wr(8'h78, 32'h7);
        wr(8'h48, 32'h5);
        ext_h <= 8'h07;
        repeat (4) @(posedge clock);
        rd(8'h80);
        chk("standby status", 32'h5, d);
        chk("standby ext_int", 32'h5, {29'h0, ext_int});
        $display("test interrupts done");
        test_done();
    end

endmodule // gph_pin_ctrl_tb

`default_nettype wire
